// *** iso_pkg.sv ***
// Purpose: Shared constants and types for the isolator channel model.
// Assumes: One core clock at 100 MHz; all timing derives from its period.
// Notes:   The refresh and watchdog counts are also top-level parameters so a bench can shorten them.

package iso_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PULSE_WIDTH_NS  = 1;
  localparam int REFRESH_IDLE_NS = 140000;
  localparam int WATCHDOG_NS     = 200000;
  localparam int RESUME_NS       = 150000;

  // A pulse shorter than a clock period still lasts one whole cycle.
  localparam int PULSE_CYC   = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (REFRESH_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WATCHDOG_CYC = (WATCHDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_CYC  = RESUME_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Structure
  // ------------------------------------------------------------------
  localparam int CNT_W        = 16;
  localparam int FIFO_DEPTH   = 8;
  localparam int DEC_GAP_CYC  = 2;
  localparam int SYNC_W       = 5;

  // Positions of the pin bundle fed through the synchroniser.
  localparam int PIN_DATA     = 0;
  localparam int PIN_DIS1     = 1;
  localparam int PIN_DIS2     = 2;
  localparam int PIN_PWR_IN   = 3;
  localparam int PIN_PWR_OUT  = 4;

  // Values after reset.
  localparam logic       DEFAULT_HIGH_RST = 1'b1;
  localparam logic [CNT_W-1:0] CNT_RST    = 16'h0000;

  // One crossing of the barrier: a set or a reset pulse.
  typedef struct packed {
    logic setPulse;
    logic resetPulse;
  } iso_pulse_s;

  localparam int PULSE_W = $bits(iso_pulse_s);

endpackage : iso_pkg

// *** iso_sync.sv ***
// Purpose: Two-flop synchroniser for a bundle of pin levels.
// Assumes: Each bit is an independent slow level.
// Notes:   Only the second stage may be read by other logic.

module iso_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Pins and their synchronised copy
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;

endmodule // iso_sync

// *** iso_fifo.sv ***
// Purpose: Small synchronous FIFO between pulse encoder and decoder.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty are exact; read data come straight from storage flops.

module iso_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Draining side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wrPtr_ff;
  logic [AW:0]      rdPtr_ff;

  wire full  = (wrPtr_ff[AW] != rdPtr_ff[AW]) && (wrPtr_ff[AW-1:0] == rdPtr_ff[AW-1:0]);
  wire empty = (wrPtr_ff == rdPtr_ff);
  wire push  = inValid && !full;
  wire pop   = outReady && !empty;

  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem_ff[rdPtr_ff[AW-1:0]];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_ff[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
    end else begin
      wrPtr_ff <= wrPtr_ff + (AW+1)'(push);
      rdPtr_ff <= rdPtr_ff + (AW+1)'(pop);
    end
  end

endmodule // iso_fifo

// *** iso_channel.sv ***
// Purpose: One isolated channel: edge encoder, barrier buffer, bistable decoder.
// Assumes: All pins are asynchronous to core_clk and pass a two-flop synchroniser.
// Notes:   A barrier pulse is one clock cycle wide; the decoder takes one pulse
//          every DEC_GAP_CYC cycles, so bursts of edges queue in the FIFO.

module iso_channel #(
  parameter int   REFRESH_CYC  = iso_pkg::REFRESH_CYC,
  parameter int   WATCHDOG_CYC = iso_pkg::WATCHDOG_CYC,
  parameter logic DEFAULT_HIGH = iso_pkg::DEFAULT_HIGH_RST
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic sys_rst,
  // Input side pins
  input  wire logic chanAInput,
  input  wire logic side1RefreshDisable,
  input  wire logic inputSideSupply,
  // Output side pins
  input  wire logic side2RefreshDisable,
  input  wire logic outputSideSupply,
  output logic      chanAOutput,
  output logic      chanAOutputEn
);

  localparam int W = iso_pkg::CNT_W;
  localparam logic [W-1:0] REF_LAST = W'(REFRESH_CYC - 1);
  localparam logic [W-1:0] WD_TOP   = W'(WATCHDOG_CYC);
  localparam logic [W-1:0] GAP_LAST = W'(iso_pkg::DEC_GAP_CYC - 1);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  logic [iso_pkg::SYNC_W-1:0] pinsSync;

  iso_sync #(
    .WIDTH (iso_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  ({outputSideSupply, inputSideSupply, side2RefreshDisable,
                side1RefreshDisable, chanAInput}),
    .syncOut  (pinsSync)
  );

  wire chanIn = pinsSync[iso_pkg::PIN_DATA];
  wire dis1   = pinsSync[iso_pkg::PIN_DIS1];
  wire dis2   = pinsSync[iso_pkg::PIN_DIS2];
  wire inPwr  = pinsSync[iso_pkg::PIN_PWR_IN];
  wire outPwr = pinsSync[iso_pkg::PIN_PWR_OUT];

  // ------------------------------------------------------------------
  // Input side: edge detect, refresh timer, pending pulse
  // ------------------------------------------------------------------
  logic           prevIn_ff;
  logic [W-1:0]   refCnt_ff;
  logic           pendValid_ff;
  logic           pendLevel_ff;
  logic           fifoInReady;

  wire inEdge     = inPwr && (chanIn != prevIn_ff);
  wire refreshDue = inPwr && !dis1 && !inEdge && (refCnt_ff == REF_LAST);
  wire launch     = inEdge || refreshDue;

  // refresh timer restart
  // Holding the timer at zero while unpowered means the first refresh after
  // power returns comes one full period later, which bounds the resume time.
  wire            refClear  = !inPwr || dis1 || launch;
  wire [W-1:0]    nxtRefCnt = refClear ? iso_pkg::CNT_RST : refCnt_ff + W'(1);

  // A newer pulse replaces one still waiting, so a full buffer never
  // reorders levels; only the latest level matters on the far side.
  wire nxtPendValid = inPwr && (launch || (pendValid_ff && !fifoInReady));
  wire nxtPendLevel = launch ? chanIn : pendLevel_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prevIn_ff    <= 1'b0;
      refCnt_ff    <= iso_pkg::CNT_RST;
      pendValid_ff <= 1'b0;
      pendLevel_ff <= 1'b0;
    end else begin
      prevIn_ff    <= chanIn;
      refCnt_ff    <= nxtRefCnt;
      pendValid_ff <= nxtPendValid;
      pendLevel_ff <= nxtPendLevel;
    end
  end

  // ------------------------------------------------------------------
  // Barrier buffer
  // ------------------------------------------------------------------
  iso_pkg::iso_pulse_s txPulse;
  iso_pkg::iso_pulse_s rxPulse;
  logic                fifoOutValid;
  logic                decReady;

  assign txPulse.setPulse   = pendLevel_ff;
  assign txPulse.resetPulse = !pendLevel_ff;

  iso_fifo #(
    .WIDTH (iso_pkg::PULSE_W),
    .DEPTH (iso_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .inValid  (pendValid_ff),
    .inData   (txPulse),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (rxPulse),
    .outReady (decReady)
  );

  // ------------------------------------------------------------------
  // Output side: decoder, watchdog, pin drive
  // ------------------------------------------------------------------
  logic           outPwrPrev_ff;
  logic [W-1:0]   gapCnt_ff;
  logic [W-1:0]   wdCnt_ff;
  logic           decodeState_ff;
  logic           outEn_ff;

  assign decReady = (gapCnt_ff == iso_pkg::CNT_RST);
  wire   popFire  = fifoOutValid && decReady;
  // Pulses that land while the output side is unpowered are lost.
  wire   rxGot    = popFire && outPwr && outPwrPrev_ff;
  wire   wdExpired = (wdCnt_ff == WD_TOP);

  wire [W-1:0] nxtGapCnt = popFire ? GAP_LAST :
                           (decReady ? gapCnt_ff : gapCnt_ff - W'(1));

  wire         wdClear  = !outPwr || dis2 || rxGot;
  wire [W-1:0] nxtWdCnt = wdClear ? iso_pkg::CNT_RST :
                          (wdExpired ? wdCnt_ff : wdCnt_ff + W'(1));

  // decoder next state
  // Power-up always starts at the default level; in low-power mode nothing
  // corrects it until the next input edge, which is the documented hazard.
  logic nxtDecodeState;
  always_comb begin
    if (!outPwr || !outPwrPrev_ff) begin
      nxtDecodeState = DEFAULT_HIGH;
    end else if (rxGot) begin
      nxtDecodeState = rxPulse.setPulse;
    end else if (wdExpired && !dis2) begin
      nxtDecodeState = DEFAULT_HIGH;
    end else begin
      nxtDecodeState = decodeState_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      outPwrPrev_ff  <= 1'b0;
      gapCnt_ff      <= iso_pkg::CNT_RST;
      wdCnt_ff       <= iso_pkg::CNT_RST;
      decodeState_ff <= DEFAULT_HIGH;
      outEn_ff       <= 1'b0;
    end else begin
      outPwrPrev_ff  <= outPwr;
      gapCnt_ff      <= nxtGapCnt;
      wdCnt_ff       <= nxtWdCnt;
      decodeState_ff <= nxtDecodeState;
      outEn_ff       <= outPwr;
    end
  end

  assign chanAOutput   = decodeState_ff;
  assign chanAOutputEn = outEn_ff;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_edge_pulse;
    logic lvl;
    (inEdge, lvl = chanIn) |=> pendValid_ff && (pendLevel_ff == lvl);
  endproperty
  a_edge_pulse: assert property (p_edge_pulse)
    else $error("Input edge did not launch a pulse of its level.");

  property p_decode_follows;
    rxGot |=> (decodeState_ff == $past(rxPulse.setPulse)) && !$past(rxPulse.resetPulse)
              == decodeState_ff;
  endproperty
  a_decode_follows: assert property (p_decode_follows)
    else $error("Decoder did not take the received pulse.");

  property p_refresh_sent;
    (inPwr && !dis1 && !inEdge && refCnt_ff == REF_LAST) |=>
      pendValid_ff && (pendLevel_ff == $past(chanIn)) && (refCnt_ff == '0);
  endproperty
  a_refresh_sent: assert property (p_refresh_sent)
    else $error("Idle timeout did not send a refresh of the present level.");

  property p_watchdog_default;
    (outPwr && outPwrPrev_ff && !dis2 && !rxGot && wdExpired) |=>
      (decodeState_ff == DEFAULT_HIGH);
  endproperty
  a_watchdog_default: assert property (p_watchdog_default)
    else $error("Watchdog expiry did not force the default level.");

  property p_refresh_off;
    dis1 |-> !refreshDue && (refCnt_ff == '0 || $past(!dis1));
  endproperty
  a_refresh_off: assert property (p_refresh_off)
    else $error("Refresh ran while disabled.");

  property p_lowpower_hold;
    (dis2 && outPwr && outPwrPrev_ff && !rxGot) |=> $stable(decodeState_ff);
  endproperty
  a_lowpower_hold: assert property (p_lowpower_hold)
    else $error("Output changed in low-power mode without a pulse.");

  property p_powerup_default;
    $rose(outPwr) |=> (decodeState_ff == DEFAULT_HIGH) ##1 chanAOutputEn;
  endproperty
  a_powerup_default: assert property (p_powerup_default)
    else $error("Output side power-up did not start at the default level.");

  property p_unpowered_float;
    !outPwr |=> !chanAOutputEn;
  endproperty
  a_unpowered_float: assert property (p_unpowered_float)
    else $error("Output driven while its side is unpowered.");

  property p_watchdog_restart;
    rxGot |=> (wdCnt_ff == '0);
  endproperty
  a_watchdog_restart: assert property (p_watchdog_restart)
    else $error("Watchdog did not restart on a received pulse.");

  property p_resume_start;
    $rose(inPwr) |-> (refCnt_ff == '0);
  endproperty
  a_resume_start: assert property (p_resume_start)
    else $error("Refresh timer not fresh at input power return.");

  property p_edge_reaches_output;
    (inEdge && outPwr && outPwrPrev_ff && !pendValid_ff && !fifoOutValid
      && decReady) ##1 (outPwr && outPwrPrev_ff) [*3] |=>
      (decodeState_ff == $past(chanIn, 4));
  endproperty
  a_edge_reaches_output: assert property (p_edge_reaches_output)
    else $error("Input edge did not reach the output.");

  // The watchdog saturates and the refresh timer restarts at its last count, so a count past its end would hide a lost refresh.
  property p_refresh_bound;
    refCnt_ff <= REF_LAST;
  endproperty
  a_refresh_bound: assert property (p_refresh_bound)
    else $error("Refresh timer ran past its last count.");

  property p_watchdog_bound;
    wdCnt_ff <= WD_TOP;
  endproperty
  a_watchdog_bound: assert property (p_watchdog_bound)
    else $error("Watchdog count ran past its top.");

  property p_pulse_pair;
    fifoOutValid |-> (rxPulse.setPulse != rxPulse.resetPulse);
  endproperty
  a_pulse_pair: assert property (p_pulse_pair)
    else $error("Barrier pulse is not exactly one of set or reset.");

  c_refresh:  cover property (refreshDue);
  c_watchdog: cover property (wdExpired && !dis2 && outPwr);
  c_full:     cover property (pendValid_ff && !fifoInReady);
  c_lowpower: cover property (dis1 && dis2 && rxGot);

endmodule // iso_channel

// *** iso_partner.sv ***
// Purpose: Far-side logic that reads the isolated output pin.
// Assumes: The pin has no pull resistor on the receiving board.
// Notes:   A released pin shows the inverse of its last driven level.

module iso_partner (
  // Clock
  input  wire logic core_clk,
  // Output pin of the channel
  input  wire logic chanAOutput,
  input  wire logic chanAOutputEn,
  // Level seen by the receiving logic
  output logic      pinLevel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lastLevel = 1'b0;

  // released pin level
  // A stale value must never pass for a live one, so a floating pin flips.
  assign pinLevel = chanAOutputEn ? chanAOutput : ~lastLevel;

  always @(posedge core_clk) begin
    if (chanAOutputEn === 1'b1) begin
      lastLevel <= chanAOutput;
    end
  end
endmodule // iso_partner

// *** iso_channel_tb.sv ***
// Purpose: Self-checking bench for one isolated channel.
// Assumes: Shortened refresh and watchdog counts; pins change at the falling edge.
// Notes:   A second instance with the low default level shares every input pin.

`define CHK(act, exp) \
  begin samplesChecked++; if ((act) !== (exp)) begin miscompares++; \
  $display("ERROR %0t output mismatch got %b want %b", $time, act, exp); end end

module iso_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int REF_CYC = 40;
  localparam int WD_CYC  = 60;
  localparam int SETTLE  = 12;

  typedef struct packed {
    logic dis;
    logic in;
    logic out;
  } iso_row_s;

  logic     core_clk            = 1'b0;
  logic     sys_rst             = 1'b1;
  logic     chanAInput          = 1'b0;
  logic     side1RefreshDisable = 1'b0;
  logic     side2RefreshDisable = 1'b0;
  logic     inputSideSupply     = 1'b1;
  logic     outputSideSupply    = 1'b1;
  logic     chanAOutput;
  logic     chanAOutputEn;
  logic     loOutput;
  logic     loOutputEn;
  logic     pinLevel;
  int       miscompares    = 0;
  int       samplesChecked = 0;
  iso_row_s rows [4] = '{'{1'b0, 1'b1, 1'b1}, '{1'b0, 1'b0, 1'b0},
                         '{1'b1, 1'b1, 1'b1}, '{1'b1, 1'b0, 1'b0}};

  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------------
  iso_channel #(.REFRESH_CYC(REF_CYC), .WATCHDOG_CYC(WD_CYC), .DEFAULT_HIGH(1'b1)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .chanAInput(chanAInput),
    .side1RefreshDisable(side1RefreshDisable), .inputSideSupply(inputSideSupply),
    .side2RefreshDisable(side2RefreshDisable), .outputSideSupply(outputSideSupply),
    .chanAOutput(chanAOutput), .chanAOutputEn(chanAOutputEn));

  iso_channel #(.REFRESH_CYC(REF_CYC), .WATCHDOG_CYC(WD_CYC), .DEFAULT_HIGH(1'b0)) dutLo (
    .core_clk(core_clk), .sys_rst(sys_rst), .chanAInput(chanAInput),
    .side1RefreshDisable(side1RefreshDisable), .inputSideSupply(inputSideSupply),
    .side2RefreshDisable(side2RefreshDisable), .outputSideSupply(outputSideSupply),
    .chanAOutput(loOutput), .chanAOutputEn(loOutputEn));

  iso_partner farSide (
    .core_clk(core_clk), .chanAOutput(chanAOutput),
    .chanAOutputEn(chanAOutputEn), .pinLevel(pinLevel));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic set_mode(input logic dis);
    side1RefreshDisable = dis;
    side2RefreshDisable = dis;
  endtask

  task automatic finish_test();
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Watchdog: the whole sequence needs about 1200 cycles.
  // ------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    step(4);
    `CHK(chanAOutput, 1'b1)
    `CHK(loOutput, 1'b0)
    `CHK(chanAOutputEn, 1'b0)
    sys_rst = 1'b0;
    step(SETTLE);
    foreach (rows[i]) begin
      set_mode(rows[i].dis);
      chanAInput = rows[i].in;
      step(SETTLE);
      `CHK(pinLevel, rows[i].out)
      `CHK(chanAOutputEn, 1'b1)
    end
    // burst of edges queues in the buffer
    set_mode(1'b0);
    for (int i = 0; i < 11; i++) begin
      chanAInput = ~chanAInput;
      step(1);
    end
    step(40);
    `CHK(chanAOutput, 1'b1)
    chanAInput = 1'b0;
    step(3 * WD_CYC);
    `CHK(chanAOutput, 1'b0)
    `CHK(loOutput, 1'b0)
    chanAInput = 1'b1;
    step(3 * WD_CYC);
    `CHK(loOutput, 1'b1)
    // dead input side forces the default
    for (int lvl = 0; lvl < 2; lvl++) begin
      chanAInput = lvl[0];
      step(SETTLE);
      inputSideSupply = 1'b0;
      step(WD_CYC + SETTLE);
      `CHK(chanAOutput, 1'b1)
      `CHK(loOutput, 1'b0)
      inputSideSupply = 1'b1;
      step(REF_CYC + SETTLE);
      `CHK(chanAOutput, lvl[0])
    end
    // low power holds the last level
    set_mode(1'b1);
    step(SETTLE);
    inputSideSupply = 1'b0;
    step(3 * WD_CYC);
    `CHK(chanAOutput, 1'b1)
    `CHK(loOutput, 1'b1)
    inputSideSupply = 1'b1;
    outputSideSupply = 1'b0;
    step(SETTLE);
    `CHK(chanAOutputEn, 1'b0)
    `CHK(loOutputEn, 1'b0)
    chanAInput = 1'b0;
    step(SETTLE);
    outputSideSupply = 1'b1;
    step(3 * WD_CYC);
    `CHK(pinLevel, 1'b1)
    chanAInput = 1'b1;
    step(SETTLE);
    chanAInput = 1'b0;
    step(SETTLE);
    `CHK(pinLevel, 1'b0)
    // reset in mid-run restores the defaults
    sys_rst = 1'b1;
    set_mode(1'b0);
    step(4);
    `CHK(chanAOutput, 1'b1)
    `CHK(loOutput, 1'b0)
    `CHK(loOutputEn, 1'b0)
    sys_rst = 1'b0;
    step(REF_CYC + SETTLE);
    `CHK(chanAOutput, 1'b0)
    `CHK(chanAOutputEn, 1'b1)
    finish_test();
  end
endmodule // iso_channel_tb
